// File: hw/hdt_monitor.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hdt_monitor
  import hdt_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = STALL_CYC
) (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // playback and sensing
  input  wire logic        playReq,
  input  wire logic        playDone,
  input  wire logic        shortDet,
  input  wire logic [7:0]  bemfLevel,
  input  wire logic [15:0] halfLen,
  input  wire logic        adcValid,
  input  wire logic [14:0] adcCode,
  input  wire logic        impValid,
  input  wire logic [9:0]  impCode,
  input  wire logic [14:0] driveDemand,
  // output stage
  output logic             driveEn,
  output logic             loopEn,
  output logic [14:0]      driveLimit,
  output hdt_cfg_t         cfg
);
  hdt_state_t  state;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [31:0] byteMask;
  logic        doWrite;
  logic [31:0] regCtrl;
  logic [31:0] regLoop;
  logic [31:0] regSup;
  logic [31:0] regDrv;
  logic [31:0] regScale;
  logic [31:0] regBemf;
  logic        phase;
  logic        shortF;
  logic        stallF;
  logic [14:0] vddRep;
  logic [9:0]  impRep;
  logic [STALL_W-1:0] stallCnt;
  logic        stallCond;
  logic        stallEvt;
  logic        shortEvt;
  logic        halfStart;
  logic        statClr;
  logic        autoClr;
  logic [14:0] marginCode;
  logic [14:0] ceiling;
  logic [31:0] rdMux;
  logic        rdHit;
  logic [3:0]  wStrb;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign byteMask[gi*8 +: 8] = {8{wStrb[gi]}};
    end
  endgenerate

  // write channel: address and data held independently
  // readies drop while frozen, else a handshake would be lost
  assign s_axi_awready = !awHeld && clkEn;
  assign s_axi_wready  = !wHeld && clkEn;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr <= OFS_IMP && awAddr[1:0] == 2'h0) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers, byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
    return ((old & ~byteMask) | (wData & byteMask)) & msk;
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      regCtrl  <= RST_CTRL;
      regLoop  <= RST_LOOP;
      regSup   <= RST_SUP;
      regDrv   <= RST_DRV;
      regScale <= RST_SCALE;
      regBemf  <= RST_BEMF;
    end else if (clkEn && doWrite) begin
      if (awAddr == OFS_CTRL) regCtrl <= merge(regCtrl, MSK_CTRL);
      if (awAddr == OFS_LOOP) regLoop <= merge(regLoop, MSK_LOOP);
      if (awAddr == OFS_SUP) regSup <= merge(regSup, MSK_SUP);
      if (awAddr == OFS_DRV) regDrv <= merge(regDrv, MSK_DRV);
      if (awAddr == OFS_SCALE) regScale <= merge(regScale, MSK_SCALE);
      if (awAddr == OFS_BEMF) regBemf <= merge(regBemf, MSK_BEMF);
    end
  end

  // settings handed to the analog stage from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg <= '0;
      cfg.uvloLevel     <= UV_2V8;
      cfg.lowSlew       <= SLEW_100;
      cfg.highSlew      <= SLEW_100;
      cfg.scaleOffsetEn <= 1'b1;
    end else if (clkEn) begin
      cfg.loopCap        <= regLoop[LOOP_CAP +: 2];
      cfg.loopRes        <= regLoop[LOOP_RES +: 2];
      cfg.loopNarrowBw   <= regLoop[LOOP_NBW];
      cfg.uvloLevel      <= regSup[SUP_UV +: 2];
      cfg.lowSlew        <= regSup[SUP_LS +: 2];
      cfg.highSlew       <= regSup[SUP_HS +: 2];
      cfg.rangeDouble    <= regCtrl[CTRL_DBL];
      // doubled range: the same code means twice the current
      cfg.peakCurrent    <= regCtrl[CTRL_DBL] ? {regDrv[DRV_PK +: 5], 1'b0}
                                              : {1'b0, regDrv[DRV_PK +: 5]};
      cfg.scaleEff       <= regCtrl[CTRL_OFS] ? regScale[15:0] + V2I_OFFSET
                                              : regScale[15:0];
      cfg.scaleOffsetEn  <= regCtrl[CTRL_OFS];
      cfg.directOverride <= regCtrl[CTRL_DRO];
      cfg.directAmp      <= regDrv[DRV_AMP +: 8];
    end
  end

  // playback state
  assign shortEvt  = (state == ST_DRIVE) && shortDet;
  assign stallCond = (state == ST_DRIVE) && (regBemf[7:0] != 8'h00)
                     && (bemfLevel < regBemf[7:0]);
  assign stallEvt  = stallCond && (stallCnt == STALL_W'(STALL_CYCLES - 1));
  assign driveEn   = (state == ST_DRIVE);
  assign loopEn    = (state == ST_DRIVE);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_INACT;
    end else if (clkEn) begin
      unique case (state)
        ST_INACT: begin
          // faults left standing block playback until cleared
          if (playReq && !shortF && !stallF) state <= ST_DRIVE;
        end
        ST_DRIVE: begin
          if (shortEvt || stallEvt || playDone) state <= ST_HALT;
        end
        ST_HALT: state <= ST_INACT;
        default: state <= ST_INACT;
      endcase
    end
  end

  // low back-emf run length
  always_ff @(posedge mclk) begin
    if (srst) begin
      stallCnt <= '0;
    end else if (clkEn) begin
      if (!stallCond || stallEvt) stallCnt <= '0;
      else stallCnt <= stallCnt + 1'b1;
    end
  end

  // fault flags: a new event wins over any clear
  assign autoClr = (state == ST_HALT) && regCtrl[CTRL_EMB];
  assign statClr = doWrite && (awAddr == OFS_STAT);

  always_ff @(posedge mclk) begin
    if (srst) begin
      shortF <= 1'b0;
      stallF <= 1'b0;
    end else if (clkEn) begin
      if (shortEvt) shortF <= 1'b1;
      else if (autoClr || (statClr && wData[STAT_SHORT] && byteMask[STAT_SHORT]))
        shortF <= 1'b0;
      if (stallEvt) stallF <= 1'b1;
      else if (autoClr || (statClr && wData[STAT_STALL] && byteMask[STAT_STALL]))
        stallF <= 1'b0;
    end
  end

  // half-period phase
  hdt_half_period u_half (
    .mclk      (mclk),
    .srst      (srst),
    .clkEn     (clkEn),
    .run       (state == ST_DRIVE),
    .halfLen   (halfLen),
    .halfStart (halfStart)
  );

  // one clock domain: flag is a single flop, read data registered again
  always_ff @(posedge mclk) begin
    if (srst) phase <= 1'b0;
    else if (clkEn && halfStart) phase <= !phase;
  end

  // supply and impedance reports
  always_ff @(posedge mclk) begin
    if (srst) begin
      vddRep <= 15'h0000;
      impRep <= 10'h000;
    end else if (clkEn) begin
      if (adcValid && state == ST_DRIVE) vddRep <= adcCode;
      // raw code; weight depends on range doubler
      if (impValid) impRep <= impCode;
    end
  end

  // headroom clamp in supply lsb units
  assign marginCode = 15'(regSup[SUP_MG +: 4] * MARGIN_LSBS);
  assign ceiling    = (vddRep > marginCode) ? vddRep - marginCode : 15'h0000;

  always_ff @(posedge mclk) begin
    if (srst) driveLimit <= 15'h0000;
    else if (clkEn)
      driveLimit <= (driveDemand > ceiling) ? ceiling : driveDemand;
  end

  // read path
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL:  rdMux = regCtrl;
      OFS_LOOP:  rdMux = regLoop;
      OFS_SUP:   rdMux = regSup;
      OFS_DRV:   rdMux = regDrv;
      OFS_SCALE: rdMux = regScale;
      OFS_BEMF:  rdMux = regBemf;
      OFS_STAT: begin
        rdMux[STAT_PH]    = phase;
        rdMux[STAT_ACT]   = (state != ST_INACT);
        rdMux[STAT_SHORT] = shortF;
        rdMux[STAT_STALL] = stallF;
      end
      OFS_VDD: begin
        rdMux[VDD_LO +: 7] = vddRep[6:0];
        rdMux[VDD_HI +: 8] = vddRep[14:7];
      end
      OFS_IMP: begin
        rdMux[IMP_LO +: 2] = impRep[1:0];
        rdMux[IMP_HI +: 8] = impRep[9:2];
      end
      default: rdHit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid && clkEn;

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence sShortHit;
    clkEn && shortEvt;
  endsequence
  sequence sStopped;
    !driveEn && !loopEn && state == ST_HALT;
  endsequence

  a_short_stop: assert property (sShortHit |=> sStopped)
    else $error("short did not stop drive");
  a_auto_clear: assert property (clkEn && autoClr |=> !shortF && !stallF)
    else $error("faults not cleared on inactive entry");
  a_phase_toggle: assert property (clkEn && halfStart |=> phase != $past(phase))
    else $error("phase missed a half-period");
  a_phase_steady: assert property (!(clkEn && halfStart) |=> $stable(phase))
    else $error("phase changed between half-periods");
  a_uvlo_reset: assert property ($fell(srst) |-> cfg.uvloLevel == UV_2V8)
    else $error("uvlo reset level wrong");
  a_slew_reset: assert property (
    $fell(srst) |-> cfg.lowSlew == SLEW_100 && cfg.highSlew == SLEW_100)
    else $error("slew reset not fastest");
  a_peak_double: assert property (
    clkEn && regCtrl[CTRL_DBL] |=> cfg.peakCurrent == {$past(regDrv[DRV_PK +: 5]), 1'b0})
    else $error("doubled peak not scaled");
  a_vdd_capture: assert property (
    clkEn && adcValid && state == ST_DRIVE |=> vddRep == $past(adcCode))
    else $error("supply sample lost");
  a_headroom_cap: assert property (clkEn |=> driveLimit <= $past(ceiling))
    else $error("drive above headroom");
  a_stall_off: assert property (
    clkEn && regBemf[7:0] == 8'h00 && !stallF |=> !stallF)
    else $error("stall fault with zero threshold");
  a_offset_gone: assert property (
    clkEn && !regCtrl[CTRL_OFS] |=> cfg.scaleEff == $past(regScale[15:0]))
    else $error("offset applied while disabled");
endmodule
`default_nettype wire

// File: hw/hdt_pkg.sv
package hdt_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned STALL_TIME_MS = 100;
  localparam int unsigned STALL_CYC     = CLK_HZ / 1000 * STALL_TIME_MS;
  localparam int unsigned STALL_W       = 22;
  // supply lsb and headroom step, both in tenths of a microvolt
  localparam int unsigned VDD_LSB_DUV   = 1831;
  localparam int unsigned MARGIN_DUV    = 1875000;
  localparam int unsigned MARGIN_LSBS   = MARGIN_DUV / VDD_LSB_DUV;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_LOOP  = 8'h04;
  localparam logic [7:0] OFS_SUP   = 8'h08;
  localparam logic [7:0] OFS_DRV   = 8'h0C;
  localparam logic [7:0] OFS_SCALE = 8'h10;
  localparam logic [7:0] OFS_BEMF  = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_VDD   = 8'h1C;
  localparam logic [7:0] OFS_IMP   = 8'h20;

  // writable bits and reset values
  localparam logic [31:0] MSK_CTRL  = 32'h0000_000F;
  localparam logic [31:0] MSK_LOOP  = 32'h0000_001F;
  localparam logic [31:0] MSK_SUP   = 32'h0000_0FF3;
  localparam logic [31:0] MSK_DRV   = 32'h0000_1FFF;
  localparam logic [31:0] MSK_SCALE = 32'h0000_FFFF;
  localparam logic [31:0] MSK_BEMF  = 32'h0000_00FF;
  localparam logic [31:0] RST_CTRL  = 32'h0000_0008;
  localparam logic [31:0] RST_LOOP  = 32'h0000_0000;
  localparam logic [31:0] RST_SUP   = 32'h0000_0F01;
  localparam logic [31:0] RST_DRV   = 32'h0000_0000;
  localparam logic [31:0] RST_SCALE = 32'h0000_0000;
  localparam logic [31:0] RST_BEMF  = 32'h0000_0000;

  // field positions
  localparam int CTRL_EMB   = 0;
  localparam int CTRL_DRO   = 1;
  localparam int CTRL_DBL   = 2;
  localparam int CTRL_OFS   = 3;
  localparam int LOOP_CAP   = 0;
  localparam int LOOP_RES   = 2;
  localparam int LOOP_NBW   = 4;
  localparam int SUP_UV     = 0;
  localparam int SUP_MG     = 4;
  localparam int SUP_LS     = 8;
  localparam int SUP_HS     = 10;
  localparam int DRV_AMP    = 0;
  localparam int DRV_PK     = 8;
  localparam int STAT_PH    = 0;
  localparam int STAT_ACT   = 1;
  localparam int STAT_SHORT = 2;
  localparam int STAT_STALL = 3;
  localparam int VDD_LO     = 0;
  localparam int VDD_HI     = 8;
  localparam int IMP_LO     = 0;
  localparam int IMP_HI     = 8;

  // codes
  localparam logic [1:0]  UV_2V8      = 2'h1;
  localparam logic [1:0]  SLEW_100    = 2'h3;
  localparam logic [15:0] V2I_OFFSET  = 16'h0010;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_INACT = 2'h0,
    ST_DRIVE = 2'h1,
    ST_HALT  = 2'h3
  } hdt_state_t;

  typedef struct packed {
    logic [1:0]  loopCap;
    logic [1:0]  loopRes;
    logic        loopNarrowBw;
    logic [1:0]  uvloLevel;
    logic [1:0]  lowSlew;
    logic [1:0]  highSlew;
    logic        rangeDouble;
    logic [5:0]  peakCurrent;
    logic [15:0] scaleEff;
    logic        scaleOffsetEn;
    logic        directOverride;
    logic [7:0]  directAmp;
  } hdt_cfg_t;
endpackage

// File: hw/hdt_half_period.sv
`timescale 1ns/1ps
`default_nettype none
module hdt_half_period
  import hdt_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // drive timing
  input  wire logic        run,
  input  wire logic [15:0] halfLen,
  output logic             halfStart
);
  logic [15:0] remain;

  // length re-sampled every half-period, so it follows the tracked period
  always_ff @(posedge mclk) begin
    if (srst) begin
      remain    <= 16'h0000;
      halfStart <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        remain    <= 16'h0000;
        halfStart <= 1'b0;
      end else if (remain == 16'h0000) begin
        remain    <= (halfLen > 16'h0001) ? halfLen - 16'h0001 : 16'h0000;
        halfStart <= 1'b1;
      end else begin
        remain    <= remain - 16'h0001;
        halfStart <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/hdt_actuator_model.sv
`timescale 1ns/1ps
`default_nettype none
module hdt_actuator_model (
  // control from bench, drive enable from the monitor
  input  wire logic        mclk,
  input  wire logic        driveEn,
  input  wire logic        shortCmd,
  input  wire logic        stallCmd,
  input  wire logic [14:0] supply,
  // sensed values
  output logic             shortDet,
  output logic [7:0]       bemfLevel,
  output logic [15:0]      halfLen,
  output logic             adcValid,
  output logic [14:0]      adcCode,
  output logic             impValid,
  output logic [9:0]       impCode
);
  logic [7:0] cnt;
  assign halfLen = 16'h0006;
  // idle sample lines toggle so no stale value passes for a fresh one
  always @(posedge mclk) begin
    cnt       <= driveEn ? cnt + 8'h01 : 8'h00;
    shortDet  <= shortCmd && driveEn;
    bemfLevel <= (driveEn && !stallCmd) ? 8'h90 : 8'h00;    // stalled rotor
    adcValid  <= driveEn && cnt[2:0] == 3'h3;
    adcCode   <= (driveEn && cnt[2:0] == 3'h3) ? supply : ~adcCode;
    impValid  <= driveEn && cnt == 8'h01;
    impCode   <= (driveEn && cnt == 8'h01) ? 10'h2B7 : ~impCode;
  end
endmodule
`default_nettype wire

// File: sim/hdt_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
module hdt_monitor_test;
  import hdt_pkg::*;
  localparam int unsigned STALL_N = 16;
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic        clkEn = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'h0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'h0;
  logic        playReq = 1'h0;
  logic        playDone = 1'h0;
  logic        shortCmd = 1'h0;
  logic        stallCmd = 1'h0;
  logic [14:0] supply = 15'h1234;
  logic [14:0] driveDemand = 15'h7FFF;
  logic        shortDet, adcValid, impValid, driveEn, loopEn;
  logic [7:0]  bemfLevel;
  logic [15:0] halfLen;
  logic [14:0] adcCode, driveLimit;
  logic [9:0]  impCode;
  hdt_cfg_t    cfg;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          failures = 0;
  int          comparisons = 0;

  always #20 mclk = ~mclk;
  hdt_monitor #(.STALL_CYCLES(STALL_N)) u_dut (.*);
  hdt_actuator_model u_act (.*);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    forever begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    rr = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    forever begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, exp, rv);
  endtask
  task automatic play;
    @(posedge mclk);
    playReq <= 1'h1;
    @(posedge mclk);
    playReq <= 1'h0;
    @(negedge mclk);
  endtask
  task automatic stop;
    @(posedge mclk);
    playDone <= 1'h1;
    @(posedge mclk);
    playDone <= 1'h0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("drive after stop", 0, driveEn);
  endtask
  task automatic t_reset;
    rdchk("ctrl reset", OFS_CTRL, 32'h0000_0008);
    chk("read resp", RESP_OKAY, rr);
    rdchk("sup reset", OFS_SUP, 32'h0000_0F01);
    rd(8'h24);
    chk("unmapped resp", RESP_DECERR, rr);
    wr(8'h06, 32'h0000_0000);
    chk("unaligned resp", RESP_DECERR, rr);
  endtask
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SUP, {20'h0_0000, i[1:0], i[1:0], 6'h00, i[1:0]});
      @(negedge mclk);
      chk("uv level", i, cfg.uvloLevel);
      chk("slews", {i[1:0], i[1:0]}, {cfg.highSlew, cfg.lowSlew});
    end
    // 20 ohm, 2 mH actuator: cap 2, res 3, narrow bandwidth
    wr(OFS_LOOP, 32'h0000_001E);
    chk("write resp", RESP_OKAY, rr);
    @(negedge mclk);
    chk("loop trims", 32'h0000_001E, {cfg.loopNarrowBw, cfg.loopRes, cfg.loopCap});
    wr(OFS_CTRL, 32'h0000_000C);
    wr(OFS_DRV, 32'h0000_13A5);
    wr(OFS_SCALE, 32'h0000_0200); // twice the real impedance
    @(negedge mclk);
    chk("peak doubled", 32'h0000_0026, cfg.peakCurrent);
    chk("scale offset", 32'h0000_0200 + V2I_OFFSET, cfg.scaleEff);
    chk("range flags", 32'h0000_0003, {cfg.rangeDouble, cfg.scaleOffsetEn});
    wr(OFS_CTRL, 32'h0000_0002);
    @(negedge mclk);
    chk("peak plain", 32'h0000_0013, cfg.peakCurrent);
    chk("scale plain", 32'h0000_0200, cfg.scaleEff);
    chk("range flags off", 0, {cfg.rangeDouble, cfg.scaleOffsetEn});
    chk("override", 1, cfg.directOverride);
  endtask
  task automatic t_phase_supply;
    logic ph;
    int   changes;
    int   lim;
    changes = 0;
    play();
    chk("drive on", 3, {driveEn, loopEn});
    rd(OFS_STAT);
    chk("active", 1, rv[STAT_ACT]);
    ph = rv[STAT_PH];
    for (int n = 0; n < 10; n++) begin
      rd(OFS_STAT);
      if (rv[STAT_PH] !== ph) begin
        changes++;
        wr(OFS_DRV, {24'h00_0000, n[7:0]});
        @(negedge mclk);
        chk("amplitude", n, cfg.directAmp);
      end
      ph = rv[STAT_PH];
    end
    chk("phase toggles", 1, changes >= 2);
    rdchk("supply", OFS_VDD, {16'h0000, supply[14:7], 1'h0, supply[6:0]});
    rdchk("impedance", OFS_IMP, 32'h0000_AD03);
    for (int m = 0; m < 6; m++) begin
      wr(OFS_SUP, {20'h0_0000, 4'hF, m[3:0], 4'h1});
      @(negedge mclk);
      lim = int'(supply) - m * 1024;
      if (lim < 0) lim = 0;
      chk("drive limit", lim, driveLimit);
    end
    wr(OFS_SUP, 32'h0000_0F01);
    @(posedge mclk);
    driveDemand <= 15'h0100;
    @(posedge mclk);
    @(negedge mclk);
    chk("demand below limit", 32'h0000_0100, driveLimit);
    // enable low: a stop request must not be acted on
    @(posedge mclk);
    clkEn    <= 1'h0;
    playDone <= 1'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("frozen drive", 1, driveEn);
    @(posedge mclk);
    clkEn    <= 1'h1;
    playDone <= 1'h0;
    stop();
  endtask
  task automatic t_fault(input logic emb);
    wr(OFS_CTRL, {31'h0000_0000, emb});
    play();
    @(posedge mclk);
    shortCmd <= 1'h1;
    repeat (4) @(posedge mclk);
    shortCmd <= 1'h0;
    @(negedge mclk);
    chk("drive off on short", 0, {driveEn, loopEn});
    rd(OFS_STAT);
    chk("short flag", !emb, rv[STAT_SHORT]);
    play();
    chk("retry", emb, driveEn);
    if (!emb) begin
      wr(OFS_STAT, 32'h0000_0004);
      play();
      chk("drive after clear", 1, driveEn);
    end
    stop();
  endtask
  task automatic t_stall;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_BEMF, 32'h0000_0040);
    play();
    @(posedge mclk);
    stallCmd <= 1'h1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk("still driving", 1, driveEn);
    repeat (STALL_N) @(posedge mclk);
    @(negedge mclk);
    chk("stall halts", 0, driveEn);
    rd(OFS_STAT);
    chk("stall flag", 1, rv[STAT_STALL]);
    wr(OFS_STAT, 32'h0000_0008);
    wr(OFS_BEMF, 32'h0000_0000);
    play();
    repeat (3 * STALL_N) @(posedge mclk);
    @(negedge mclk);
    chk("zero threshold", 1, driveEn);
    @(posedge mclk);
    stallCmd <= 1'h0;
    stop();
  endtask
  task automatic results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    t_reset();
    t_fields();
    t_phase_supply();
    t_fault(1'h1);
    t_fault(1'h0);
    t_stall();
    results();
  end
  // run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("MISMATCH watchdog expected finish seen timeout");
    results();
  end
endmodule
`default_nettype wire
